//--- rtl/eepws_pkg.sv
// constants, states and address map of the nonvolatile write sequencer
`default_nettype none
package eepws_pkg;

    // clock and timing
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned QUIET_US       = 120;
    localparam int unsigned STORE_US       = 5000;
    localparam int unsigned FL_PGM_US      = 10;
    localparam int unsigned ERASE_MS       = 1000;
    localparam int unsigned QUIET_CYCLES   = QUIET_US * CLK_MHZ;
    localparam int unsigned STORE_CYCLES   = STORE_US * CLK_MHZ;
    localparam int unsigned FL_PGM_CYCLES  = FL_PGM_US * CLK_MHZ;
    localparam int unsigned ERASE_CYCLES   = ERASE_MS * 1000 * CLK_MHZ;

    // bus address map, 17-bit byte addresses
    localparam logic [1:0]  REGION_EE      = 2'h0;
    localparam logic [1:0]  REGION_FL      = 2'h1;
    localparam logic [16:0] REG_STATUS     = 17'h10000;
    localparam logic [16:0] REG_ERASE      = 17'h10001;

    // instruction addresses and data
    localparam logic [14:0] CMD_ADR1       = 15'h0555;
    localparam logic [14:0] CMD_ADR2       = 15'h0AAA;
    localparam logic [7:0]  CMD_AA         = 8'hAA;
    localparam logic [7:0]  CMD_55         = 8'h55;
    localparam logic [7:0]  CMD_LOCK_ON    = 8'hA0;
    localparam logic [7:0]  CMD_UNLOCK     = 8'h80;
    localparam logic [7:0]  CMD_UNLOCK_END = 8'h20;
    localparam logic [7:0]  CMD_OTP        = 8'h90;
    localparam logic [7:0]  CMD_FL_PGM     = 8'hA0;
    localparam logic [7:0]  CMD_FL_RESET   = 8'hF0;

    // data bus status bit positions
    localparam int unsigned POLL_BIT       = 7;
    localparam int unsigned TOGGLE_BIT     = 6;
    localparam int unsigned ERROR_BIT      = 5;

    // status register bits
    localparam int unsigned ST_LOCK        = 0;
    localparam int unsigned ST_EE_BUSY     = 1;
    localparam int unsigned ST_FL_BUSY     = 2;
    localparam int unsigned ST_FL_ERR      = 3;
    localparam int unsigned ST_SEQ         = 4;

    // erase control register fields and sector address lsb
    localparam int unsigned ERASE_GO       = 7;
    localparam int unsigned ERASE_BULK     = 6;
    localparam int unsigned SECTOR_LSB     = 12;

    localparam int unsigned PAGE_BYTES     = 64;
    localparam logic [7:0]  ERASED         = 8'hFF;
    localparam logic        LOCK_SHIPPED   = 1'b0;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_AA   = 3'b001,
        SEQ_55   = 3'b010,
        SEQ_DIS1 = 3'b011,
        SEQ_DIS2 = 3'b100,
        SEQ_DIS3 = 3'b101,
        SEQ_DATA = 3'b110,
        SEQ_OTP  = 3'b111
    } eepws_seq_e;

endpackage
`default_nettype wire

//--- rtl/eepws_top.sv
// page write, write lock and flash status sequencer behind a wishbone slave
`timescale 1ns/1ps
`default_nettype none
module eepws_top #(
    parameter int unsigned QUIET_CYCLES = eepws_pkg::QUIET_CYCLES,
    parameter int unsigned STORE_CYCLES = eepws_pkg::STORE_CYCLES,
    parameter int unsigned ERASE_CYCLES = eepws_pkg::ERASE_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [16:0] adr_i,
    input  wire logic        sel_i,
    input  wire logic [7:0]  dat_i,
    output logic      [7:0]  dat_o,
    output logic             ack_o,
    output logic             eeprom_sector_select_o,
    output logic             ready_busy_o
);

    typedef struct packed {
        logic                   ack;
        logic [7:0]             rdat;
        logic                   tog;
        logic                   ee_busy;
        logic                   ee_timing;
        logic [19:0]            ee_cnt;
        eepws_pkg::eepws_seq_e  seq;
        logic                   unlocked;
        logic                   lock_pend;
        logic                   lock_new;
        logic                   poll_ok;
        logic                   otp_tgt;
        logic [8:0]             page;
        logic [63:0]            buf_vld;
        logic [63:0][7:0]       buf_dat;
        logic                   last_d7;
        logic [1:0]             fl_step;
        logic                   fl_busy;
        logic                   fl_fail;
        logic                   fl_err;
        logic                   fl_erase;
        logic                   fl_bulk;
        logic [2:0]             fl_sector;
        logic [14:0]            fl_adr;
        logic [7:0]             fl_data;
        logic [26:0]            fl_cnt;
    } eepws_state_s;

    eepws_state_s s_q;
    eepws_state_s s_d;

    logic [7:0]  ee_mem   [0:32767];
    logic [7:0]  fl_mem   [0:32767];
    logic [7:0]  otp_mem  [0:63];
    logic [63:0] otp_used = '0;
    logic        lock_q   = eepws_pkg::LOCK_SHIPPED;

    logic        req;
    logic        wr;
    logic        rd;
    logic        in_ee;
    logic        in_fl;
    logic [14:0] a;
    logic [7:0]  ee_rd;
    logic [7:0]  fl_rd;
    logic        quiet_done;
    logic        ee_commit;
    logic        fl_done;
    logic        fl_hit;
    logic        is_adr1;
    logic        is_adr2;

    assign req        = cyc_i & stb_i & ~s_q.ack;
    assign wr         = req & we_i & sel_i;
    assign rd         = req & ~we_i;
    assign a          = adr_i[14:0];
    assign in_ee      = ~adr_i[16] & (adr_i[16:15] == eepws_pkg::REGION_EE);
    assign in_fl      = ~adr_i[16] & (adr_i[16:15] == eepws_pkg::REGION_FL);
    assign is_adr1    = (a == eepws_pkg::CMD_ADR1);
    assign is_adr2    = (a == eepws_pkg::CMD_ADR2);
    assign ee_rd      = ee_mem[a];
    assign fl_rd      = fl_mem[a];
    // quiet period counted in clock cycles
    assign quiet_done = s_q.ee_timing & (s_q.ee_cnt == 20'(QUIET_CYCLES - 1));
    assign ee_commit  = s_q.ee_busy & (s_q.ee_cnt == 20'(STORE_CYCLES - 1));
    assign fl_done    = s_q.fl_busy & (s_q.fl_cnt == (s_q.fl_erase ? 27'(ERASE_CYCLES - 1)
                                                                 : 27'(eepws_pkg::FL_PGM_CYCLES - 1)));
    // erase status on any sector address, program status on the target only
    assign fl_hit     = s_q.fl_erase ? (s_q.fl_bulk | (a[14:eepws_pkg::SECTOR_LSB] == s_q.fl_sector))
                                     : (a == s_q.fl_adr);

    assign dat_o                  = s_q.rdat;
    assign ack_o                  = s_q.ack;
    assign eeprom_sector_select_o = req & in_ee;
    // low from the first sequence write until storage ends, and while the flash programs or erases
    assign ready_busy_o           = ~(s_q.ee_busy | (s_q.seq != eepws_pkg::SEQ_IDLE) | s_q.fl_busy);

    always_comb
    begin
        s_d       = s_q;
        s_d.ack   = req;
        s_d.rdat  = 8'h00;
        s_d.ee_cnt = s_q.ee_cnt + 20'h00001;
        s_d.fl_cnt = s_q.fl_busy ? s_q.fl_cnt + 27'h0000001 : s_q.fl_cnt;

        // quiet period over: launch storage or drop a broken sequence
        if (quiet_done)
        begin
            s_d.ee_timing = 1'b0;
            s_d.seq       = eepws_pkg::SEQ_IDLE;
            s_d.unlocked  = 1'b0;
            if ((|s_q.buf_vld) | s_q.lock_pend)
            begin
                s_d.ee_busy = 1'b1;
                s_d.ee_cnt  = 20'h00000;
                s_d.poll_ok = ~s_q.lock_pend;
            end
        end
        if (ee_commit)
        begin
            s_d.ee_busy   = 1'b0;
            s_d.buf_vld   = '0;
            s_d.lock_pend = 1'b0;
            s_d.otp_tgt   = 1'b0;
        end
        if (fl_done)
        begin
            s_d.fl_busy = 1'b0;
        end

        // eeprom writes ignored while storing
        if (wr & in_ee & ~s_q.ee_busy)
        begin
            s_d.ee_cnt    = 20'h00000;
            s_d.ee_timing = 1'b1;
            case (s_q.seq)
                eepws_pkg::SEQ_IDLE:
                begin
                    if (is_adr1 & (dat_i == eepws_pkg::CMD_AA) & ~(|s_q.buf_vld))
                    begin
                        s_d.seq = eepws_pkg::SEQ_AA;
                    end
                    else if (~lock_q)
                    begin
                        // page load
                        if (~(|s_q.buf_vld))
                        begin
                            s_d.page = a[14:6];
                        end
                        s_d.buf_dat[a[5:0]] = dat_i;
                        s_d.buf_vld[a[5:0]] = 1'b1;
                        s_d.last_d7         = dat_i[eepws_pkg::POLL_BIT];
                    end
                    else
                    begin
                        s_d.ee_timing = |s_q.buf_vld; // locked write refused
                    end
                end
                eepws_pkg::SEQ_AA:
                begin
                    s_d.seq = (is_adr2 & (dat_i == eepws_pkg::CMD_55)) ? eepws_pkg::SEQ_55
                                                                      : eepws_pkg::SEQ_IDLE;
                end
                eepws_pkg::SEQ_55:
                begin
                    s_d.seq = eepws_pkg::SEQ_IDLE;
                    if (is_adr1 & (dat_i == eepws_pkg::CMD_LOCK_ON))
                    begin
                        // enable, or unlock for the following data
                        s_d.seq      = eepws_pkg::SEQ_DATA;
                        s_d.unlocked = 1'b1;
                        if (~lock_q)
                        begin
                            s_d.lock_pend = 1'b1;
                            s_d.lock_new  = 1'b1;
                        end
                    end
                    else if (is_adr1 & (dat_i == eepws_pkg::CMD_UNLOCK))
                    begin
                        s_d.seq = eepws_pkg::SEQ_DIS1;
                    end
                    else if (is_adr1 & (dat_i == eepws_pkg::CMD_OTP) & ~lock_q)
                    begin
                        s_d.seq = eepws_pkg::SEQ_OTP; // refused under lock
                    end
                end
                eepws_pkg::SEQ_DIS1:
                begin
                    s_d.seq = (is_adr1 & (dat_i == eepws_pkg::CMD_AA)) ? eepws_pkg::SEQ_DIS2
                                                                      : eepws_pkg::SEQ_IDLE;
                end
                eepws_pkg::SEQ_DIS2:
                begin
                    s_d.seq = (is_adr2 & (dat_i == eepws_pkg::CMD_55)) ? eepws_pkg::SEQ_DIS3
                                                                      : eepws_pkg::SEQ_IDLE;
                end
                eepws_pkg::SEQ_DIS3:
                begin
                    if (is_adr1 & (dat_i == eepws_pkg::CMD_UNLOCK_END))
                    begin
                        s_d.seq       = eepws_pkg::SEQ_DIS3; // held until storage starts
                        s_d.lock_pend = 1'b1;
                        s_d.lock_new  = 1'b0;
                    end
                    else
                    begin
                        s_d.seq = eepws_pkg::SEQ_IDLE;
                    end
                end
                eepws_pkg::SEQ_DATA:
                begin
                    if (~(|s_q.buf_vld))
                    begin
                        s_d.page = a[14:6];
                    end
                    s_d.buf_dat[a[5:0]] = dat_i;
                    s_d.buf_vld[a[5:0]] = 1'b1;
                    s_d.last_d7         = dat_i[eepws_pkg::POLL_BIT];
                end
                eepws_pkg::SEQ_OTP:
                begin
                    if (~a[6])
                    begin
                        s_d.otp_tgt         = 1'b1;
                        s_d.buf_dat[a[5:0]] = dat_i;
                        s_d.buf_vld[a[5:0]] = 1'b1;
                        s_d.last_d7         = dat_i[eepws_pkg::POLL_BIT];
                    end
                end
                default:
                begin
                    s_d.seq = eepws_pkg::SEQ_IDLE;
                end
            endcase
        end

        // flash program instruction and reset
        if (wr & in_fl & ~s_q.fl_busy)
        begin
            if (dat_i == eepws_pkg::CMD_FL_RESET)
            begin
                s_d.fl_step = 2'h0;
                s_d.fl_fail = 1'b0;
                s_d.fl_err  = 1'b0;
            end
            else
            begin
                case (s_q.fl_step)
                    2'h0:    s_d.fl_step = (is_adr1 & (dat_i == eepws_pkg::CMD_AA)) ? 2'h1 : 2'h0;
                    2'h1:    s_d.fl_step = (is_adr2 & (dat_i == eepws_pkg::CMD_55)) ? 2'h2 : 2'h0;
                    2'h2:    s_d.fl_step = (is_adr1 & (dat_i == eepws_pkg::CMD_FL_PGM)) ? 2'h3 : 2'h0;
                    default:
                    begin
                        s_d.fl_step  = 2'h0;
                        s_d.fl_adr   = a;
                        s_d.fl_data  = dat_i;
                        s_d.fl_erase = 1'b0;
                        s_d.fl_cnt   = 27'h0000000;
                        if (|(dat_i & ~fl_rd))
                        begin
                            s_d.fl_fail = 1'b1; // one over zero
                            s_d.fl_err  = 1'b1;
                        end
                        else
                        begin
                            s_d.fl_busy = 1'b1;
                            s_d.fl_fail = 1'b0;
                            s_d.fl_err  = 1'b0;
                        end
                    end
                endcase
            end
        end

        // erase launch register
        if (wr & (adr_i == eepws_pkg::REG_ERASE) & ~s_q.fl_busy & dat_i[eepws_pkg::ERASE_GO])
        begin
            s_d.fl_busy   = 1'b1;
            s_d.fl_erase  = 1'b1;
            s_d.fl_bulk   = dat_i[eepws_pkg::ERASE_BULK];
            s_d.fl_sector = dat_i[2:0];
            s_d.fl_cnt    = 27'h0000000;
            s_d.fl_fail   = 1'b0;
            s_d.fl_err    = 1'b0;
            s_d.fl_step   = 2'h0;
        end

        // read data and status
        if (rd)
        begin
            if (in_ee)
            begin
                if (s_q.ee_busy | (|s_q.buf_vld) | s_q.lock_pend)
                begin
                    s_d.rdat[eepws_pkg::POLL_BIT]   = s_q.poll_ok & ~s_q.last_d7 & s_q.ee_busy;
                    s_d.rdat[eepws_pkg::TOGGLE_BIT] = s_q.tog;
                    s_d.tog                         = ~s_q.tog;
                end
                else
                begin
                    s_d.rdat = ee_rd;
                end
            end
            else if (in_fl)
            begin
                if ((s_q.fl_busy | s_q.fl_fail) & fl_hit)
                begin
                    s_d.rdat[eepws_pkg::POLL_BIT]   = ~s_q.fl_erase & ~s_q.fl_data[7];
                    s_d.rdat[eepws_pkg::TOGGLE_BIT] = s_q.tog;
                    s_d.rdat[eepws_pkg::ERROR_BIT]  = s_q.fl_err;
                    s_d.tog                         = ~s_q.tog;
                end
                else
                begin
                    s_d.rdat = fl_rd;
                end
            end
            else if (adr_i == eepws_pkg::REG_STATUS)
            begin
                s_d.rdat[eepws_pkg::ST_LOCK]    = lock_q;
                s_d.rdat[eepws_pkg::ST_EE_BUSY] = s_q.ee_busy;
                s_d.rdat[eepws_pkg::ST_FL_BUSY] = s_q.fl_busy;
                s_d.rdat[eepws_pkg::ST_FL_ERR]  = s_q.fl_err;
                s_d.rdat[eepws_pkg::ST_SEQ]     = s_q.seq != eepws_pkg::SEQ_IDLE;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // nonvolatile arrays and lock, untouched by reset
    always_ff @(posedge clk_i)
    begin
        if (ee_commit & ~rst_i)
        begin
            if (s_q.lock_pend)
            begin
                lock_q <= s_q.lock_new;
            end
            for (int i = 0; i < eepws_pkg::PAGE_BYTES; i++)
            begin
                if (s_q.buf_vld[i] & s_q.otp_tgt & ~otp_used[i])
                begin
                    otp_mem[i]  <= s_q.buf_dat[i];
                    otp_used[i] <= 1'b1;
                end
                else if (s_q.buf_vld[i] & ~s_q.otp_tgt)
                begin
                    ee_mem[{s_q.page, 6'(i)}] <= s_q.buf_dat[i];
                end
            end
        end
        if (fl_done & ~rst_i)
        begin
            if (~s_q.fl_erase)
            begin
                fl_mem[s_q.fl_adr] <= fl_mem[s_q.fl_adr] & s_q.fl_data;
            end
            else
            begin
                for (int j = 0; j < 32768; j++)
                begin
                    if (s_q.fl_bulk | (j[14:eepws_pkg::SECTOR_LSB] == s_q.fl_sector))
                    begin
                        fl_mem[j] <= eepws_pkg::ERASED;
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- testbench/eepws_top_properties.sv
// bus timing and ready/busy assertions for the sequencer
`timescale 1ns/1ps
`default_nettype none
module eepws_top_properties #(
    parameter int unsigned QUIET_CYCLES = 15000,
    parameter int unsigned STORE_CYCLES = 625000,
    parameter int unsigned ERASE_CYCLES = 125000000
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [16:0] adr_i,
    input wire logic        sel_i,
    input wire logic [7:0]  dat_i,
    input wire logic [7:0]  dat_o,
    input wire logic        ack_o,
    input wire logic        eeprom_sector_select_o,
    input wire logic        ready_busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic tk;
    assign tk = cyc_i && stb_i && !ack_o;
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_answer; tk |=> ack_o; endproperty
    a_answer: assert property (p_answer) else $error("no ack");
    property p_no_stray; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_no_stray: assert property (p_no_stray) else $error("stray ack");
    property p_wr_zero; ack_o && we_i |-> dat_o == 8'h00; endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("write data out");
    property p_sel_on; tk && adr_i[16:15] == 2'h0 |-> eeprom_sector_select_o; endproperty
    a_sel_on: assert property (p_sel_on) else $error("select low");
    property p_sel_off; eeprom_sector_select_o |-> cyc_i && stb_i && adr_i[16:15] == 2'h0; endproperty
    a_sel_off: assert property (p_sel_off) else $error("select stray");
    property p_rdy_rst; $past(rst_i) |-> ready_busy_o; endproperty
    a_rdy_rst: assert property (p_rdy_rst) else $error("busy after reset");
    property p_aa_busy;
        tk && we_i && sel_i && adr_i == 17'h00555 && dat_i == 8'hAA && ready_busy_o |=> !ready_busy_o;
    endproperty
    a_aa_busy: assert property (p_aa_busy) else $error("ready after first AA");
    property p_st_busy;
        ack_o && $past(tk && !we_i && adr_i == 17'h10000) && dat_o[1] |-> $past(!ready_busy_o);
    endproperty
    a_st_busy: assert property (p_st_busy) else $error("busy bit while ready");
endmodule
bind eepws_top eepws_top_properties #(.QUIET_CYCLES(QUIET_CYCLES), .STORE_CYCLES(STORE_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) i_eepws_top_properties (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .eeprom_sector_select_o(eeprom_sector_select_o), .ready_busy_o(ready_busy_o));
`default_nettype wire

//--- testbench/eepws_mcu.sv
// microcontroller model issuing classic wishbone cycles
`timescale 1ns/1ps
`default_nettype none
module eepws_mcu (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [7:0]  rdat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [16:0]      adr_o,
    output logic             sel_o,
    output logic [7:0]       wdat_o,
    output logic             tout_o
);
    int unsigned gap = 0;
    initial
    begin
        {cyc_o, stb_o, we_o, sel_o, tout_o} = 5'h00;
        adr_o = 17'h00000;
        wdat_o = 8'h00;
    end
    // one cycle held until ack; short gaps keep sequences in time
    task automatic xfer(input logic w, input logic [16:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        repeat (gap) @(posedge clk_i);
        {cyc_o, stb_o, we_o, sel_o, adr_o, wdat_o} <= {2'b11, w, 1'b1, a, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (!ack_i && n < 20);
        q = rdat_i;
        if (!ack_i)
            tout_o <= 1'b1;
        {cyc_o, stb_o} <= 2'b00;
        adr_o <= ~a;
        wdat_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

//--- testbench/test_eepws_top.sv
// self-checking bench for the write sequencer
`timescale 1ns/1ps
`default_nettype none
module test_eepws_top;
    localparam int unsigned QC = 20;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, sel, ack, sect, rdy, tout;
    logic [16:0] adr;
    logic [7:0]  wd, rd, q, q2, d, pat [64];
    int          num_errors = 0;
    int          num_checks = 0;
    always #4 clk_i = ~clk_i;
    eepws_top #(.QUIET_CYCLES(QC), .STORE_CYCLES(40), .ERASE_CYCLES(60)) i_eepws_top (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd),
        .dat_o(rd), .ack_o(ack), .eeprom_sector_select_o(sect), .ready_busy_o(rdy));
    eepws_mcu i_eepws_mcu (.clk_i(clk_i), .ack_i(ack), .rdat_i(rd), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .wdat_o(wd), .tout_o(tout));
    function automatic logic [7:0] pgm(input logic [7:0] o, input logic [7:0] n);
        return o & n;
    endfunction
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [16:0] a, input logic [7:0] v);
        i_eepws_mcu.xfer(1'b1, a, v, q2);
    endtask
    task automatic rdc(input logic [16:0] a, output logic [7:0] v);
        i_eepws_mcu.xfer(1'b0, a, 8'h00, v);
    endtask
    task automatic pre(input logic [16:0] b, input logic [7:0] c);
        wr(b | 17'h00555, 8'hAA);
        wr(b | 17'h00AAA, 8'h55);
        wr(b | 17'h00555, c);
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 2000)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 2000)
        begin
            num_errors++;
            close_out();
        end
    endtask
    always @(posedge tout)
    begin
        num_errors++;
        close_out();
    end
    initial
    begin
        logic [16:0] pg;
        logic [16:0] fa;
        void'($urandom(32'hCAE08647));
        i_eepws_mcu.gap = $urandom_range(0, 2);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        pg = {2'b00, 9'($urandom), 6'h00};
        fa = pg | 17'h08000;
        for (int i = 0; i < 64; i++)
            pat[i] = 8'($urandom);
        for (int i = 63; i >= 0; i -= 21)
            wr(pg + 17'(i), pat[i]);
        chk("ready while loading", 8'(rdy), 8'h01);
        rdc(pg, q);
        chk("poll while loading", 8'(q[7]), 8'h00);
        rdc(pg, q2);
        chk("toggle", 8'(q2[6]), {7'h00, ~q[6]});
        repeat (QC) @(posedge clk_i);
        wr(pg + 17'd21, ~pat[21]);
        rdc(pg + 17'd63, q);
        chk("poll storing", 8'(q[7]), {7'h00, ~pat[0][7]});
        rdc(eepws_pkg::REG_STATUS, q);
        chk("ee busy bit", 8'(q[1]), 8'h01);
        wait_rdy();
        for (int i = 0; i < 64; i += 21)
        begin
            rdc(pg + 17'(i), q);
            chk("page byte", q, pat[i]);
        end
        rdc(17'h1FFFF, q);
        chk("unmapped", q, 8'h00);
        pre(17'h00000, eepws_pkg::CMD_LOCK_ON);
        d = 8'($urandom);
        wr(pg, d);
        wait_rdy();
        rdc(eepws_pkg::REG_STATUS, q);
        chk("lock on", 8'(q[0]), 8'h01);
        rdc(pg, q);
        chk("unlocked write", q, d);
        wr(pg, ~d);
        chk("locked write idle", 8'(rdy), 8'h01);
        rdc(pg, q);
        chk("locked write kept", q, d);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(eepws_pkg::REG_STATUS, q);
        chk("lock over reset", 8'(q[0]), 8'h01);
        rdc(pg, q);
        chk("array over reset", q, d);
        pre(17'h00000, eepws_pkg::CMD_OTP);
        wr(17'h00005, d);
        chk("row write refused idle", 8'(rdy), 8'h01);
        wait_rdy();
        rdc(eepws_pkg::REG_STATUS, q);
        chk("row write refused", 8'(q[4:0]), 8'h01);
        pre(17'h00000, eepws_pkg::CMD_UNLOCK);
        pre(17'h00000, eepws_pkg::CMD_UNLOCK_END);
        wait_rdy();
        rdc(eepws_pkg::REG_STATUS, q);
        chk("lock off", 8'(q[4:0]), 8'h00);
        pre(17'h00000, eepws_pkg::CMD_OTP);
        wr(17'h00005, d);
        chk("row write taken", 8'(rdy), 8'h00);
        wait_rdy();
        wr(eepws_pkg::REG_ERASE, 8'hC0);
        rdc(fa, q);
        chk("erase poll", 8'({q[7], q[5]}), 8'h00);
        wait_rdy();
        rdc(fa, q);
        chk("erased", q, eepws_pkg::ERASED);
        d = 8'($urandom) & 8'hFE;
        pre(17'h08000, eepws_pkg::CMD_FL_PGM);
        wr(fa, d);
        rdc(fa, q);
        chk("program poll", 8'(q[7]), {7'h00, ~d[7]});
        wait_rdy();
        rdc(fa, q);
        chk("programmed", q, d);
        q2 = 8'($urandom);
        pre(17'h08000, eepws_pkg::CMD_FL_PGM);
        wr(fa, pgm(d, q2));
        wait_rdy();
        rdc(fa, q);
        chk("bits only clear", q, pgm(d, q2));
        pre(17'h08000, eepws_pkg::CMD_FL_PGM);
        wr(fa, 8'hFF);
        rdc(fa, q);
        chk("error bit", 8'(q[5]), 8'h01);
        wr(17'h08000, eepws_pkg::CMD_FL_RESET);
        rdc(eepws_pkg::REG_STATUS, q);
        chk("error cleared", 8'(q[3]), 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
